// [vib_pkg.sv]
// Purpose: shared constants and types for the vibration supervision block
// Assumes: 50 MHz hclk, 32-bit AHB-Lite register bus, one word per register
// Notes:   byte offsets are word aligned; 16-bit settings sit in the low bits
package vib_pkg;

  // register byte offsets
  localparam logic [7:0] OFF_SELECT   = 8'h00;
  localparam logic [7:0] OFF_SENS     = 8'h04;
  localparam logic [7:0] OFF_LEVEL    = 8'h08;
  localparam logic [7:0] OFF_PREP     = 8'h0c;
  localparam logic [7:0] OFF_STATUS   = 8'h10;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h14;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h18;
  localparam logic [7:0] OFF_MEASURE  = 8'h1c;

  // reset values and limits
  localparam logic [15:0] SELECT_RST  = 16'h0000;
  localparam logic [15:0] SENS_RST    = 16'h0064;
  localparam logic [15:0] SENS_MIN    = 16'h0032;
  localparam logic [15:0] SENS_MAX    = 16'h01f4;
  localparam logic [31:0] PERCENT     = 32'h0000_0064;
  localparam logic [31:0] SLOW_PCT    = 32'h0000_000a;

  // selection digit codes
  localparam logic [1:0] SEL_NONE  = 2'h0;
  localparam logic [1:0] SEL_WARN  = 2'h1;
  localparam logic [1:0] SEL_ALARM = 2'h2;

  // field positions
  localparam int PREP_WRITE_OK_BIT  = 0;
  localparam int PREP_MOTORLESS_BIT = 1;
  localparam int IRQ_WARN_BIT       = 0;
  localparam int IRQ_ALARM_BIT      = 1;
  localparam int IRQ_DONE_BIT       = 2;
  localparam int IRQ_ERROR_BIT      = 3;
  localparam int IRQ_W              = 4;

  // timing
  localparam int CLK_HZ        = 50_000_000;
  localparam int LONG_PRESS_MS = 1000;
  localparam int LONG_PRESS_CYC = (CLK_HZ / 1000) * LONG_PRESS_MS;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_LEARN = 3'b010,
    ST_STORE = 3'b100
  } learn_state_e;

  typedef struct packed {
    logic warning;
    logic alarm;
  } vib_out_s;

  typedef struct packed {
    logic flash;
    logic done;
    logic error;
  } learn_out_s;

endpackage : vib_pkg

// [vib_sync3.sv]
// Purpose: three-stage synchroniser for pin inputs, with agreement filter
// Assumes: inputs are asynchronous to hclk
// Notes:   output follows only once stages two and three agree
`timescale 1ns/1ns
`default_nettype none
module vib_sync3 #(
  parameter int W = 1
) (
  // clock, reset and enable
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic         ce,
  // data
  input  wire logic [W-1:0] din,
  output var  logic [W-1:0] dout
);

  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        s1[i]   <= 1'b0;
        s2[i]   <= 1'b0;
        s3[i]   <= 1'b0;
        dout[i] <= 1'b0;
      end else if (ce) begin
        s1[i] <= din[i];
        s2[i] <= s1[i];
        s3[i] <= s2[i];
        if (s2[i] == s3[i]) begin
          dout[i] <= s3[i];
        end
      end
    end
  end

endmodule : vib_sync3
`default_nettype wire

// [vib_detect.sv]
// Purpose: vibration supervision with learning of the detection level
// Assumes: vibration and speed inputs come from hclk logic; learn key is a pin
// Notes:   ce low freezes all state; keep ce high while using the bus
// Contract
// - selection 0 none, 1 warning, 2 alarm
// - selection resets to none, applies at once
// - threshold is level times sensitivity over 100
// - sensitivity 50 to 500 percent, default 100
// - learning needs write permitted setting
// - learning needs motorless test disabled
// - long press starts learning, flashing, measuring
// - speed at or below 10 percent gives error
// - next press stores level, reports done or error
// - sensitivity writable, level locked during learning
// - learning overwrites level, never sensitivity
// - vibration judged in speed units
`timescale 1ns/1ns
`default_nettype none
module vib_detect
  import vib_pkg::*;
#(
  parameter logic [15:0] LEVEL_INIT     = 16'h0032,
  parameter logic [15:0] MAX_SPEED      = 16'h1770,
  parameter int          LONG_PRESS_CNT = vib_pkg::LONG_PRESS_CYC
) (
  // clock, reset, enable
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              ce,
  // ahb-lite slave
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output var  logic [31:0]       hrdata,
  output var  logic              hreadyout,
  output var  logic              hresp,
  // drive side
  input  wire logic [15:0]       vib_speed,
  input  wire logic [15:0]       motor_speed,
  input  wire logic              learn_key,
  output var  vib_pkg::vib_out_s   vib_out,
  output var  vib_pkg::learn_out_s learn_out,
  output var  logic              irq
);
  import vib_pkg::*;

  logic [15:0]  sel_reg;
  logic [15:0]  sens;
  logic [15:0]  level;
  logic         write_ok;
  logic         motorless;
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_mask;
  learn_state_e state;
  logic [15:0]  cand;
  logic         slow_err;
  logic [31:0]  press_cnt;
  logic         key_s;
  logic         key_prev;
  logic         wr_pend;
  logic [7:0]   wr_addr;
  logic         done_ev;
  logic         err_ev;

  vib_sync3 #(.W(1)) u_key_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ce      (ce),
    .din     (learn_key),
    .dout    (key_s)
  );

  // detection: vibration is already a speed figure, so no unit change
  logic [31:0] vib_scaled;
  logic [31:0] thresh_scaled;
  logic        det;
  logic        slow;
  logic        prep_ok;
  logic        long_fire;
  logic        key_rise;
  assign vib_scaled    = 32'(vib_speed) * PERCENT;
  assign thresh_scaled = 32'(level) * 32'(sens);
  assign det           = vib_scaled > thresh_scaled;
  assign slow          = (32'(motor_speed) * PERCENT) <= (32'(MAX_SPEED) * SLOW_PCT);
  assign prep_ok       = write_ok && !motorless;
  assign long_fire     = key_s && (press_cnt == 32'(LONG_PRESS_CNT - 1));
  assign key_rise      = key_s && !key_prev;

  // bus address phase
  logic acc;
  assign acc = hsel && hready && htrans[1];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend   <= 1'b0;
      wr_addr   <= 8'h00;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else if (ce) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (hready) begin
        wr_pend <= acc && hwrite && (hsize == 3'h2);
        wr_addr <= haddr[7:0];
      end
    end
  end

  // read data registered in the address phase, so it stands in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (ce && acc && !hwrite) begin
      case (haddr[7:0])
        OFF_SELECT:   hrdata <= {16'h0000, sel_reg};
        OFF_SENS:     hrdata <= {16'h0000, sens};
        OFF_LEVEL:    hrdata <= {16'h0000, level};
        OFF_PREP:     hrdata <= {30'h0, motorless, write_ok};
        OFF_STATUS:   hrdata <= {24'h0, slow_err, state, 1'b0, learn_out};
        OFF_IRQ_STAT: hrdata <= {28'h0, irq_stat};
        OFF_IRQ_MASK: hrdata <= {28'h0, irq_mask};
        OFF_MEASURE:  hrdata <= {cand, vib_speed};
        default:      hrdata <= 32'h0000_0000;
      endcase
    end
  end

  logic wr_sel;
  logic wr_sens;
  logic wr_level;
  logic wr_prep;
  logic wr_istat;
  logic wr_imask;
  assign wr_sel   = wr_pend && (wr_addr == OFF_SELECT);
  assign wr_sens  = wr_pend && (wr_addr == OFF_SENS);
  assign wr_level = wr_pend && (wr_addr == OFF_LEVEL);
  assign wr_prep  = wr_pend && (wr_addr == OFF_PREP);
  assign wr_istat = wr_pend && (wr_addr == OFF_IRQ_STAT);
  assign wr_imask = wr_pend && (wr_addr == OFF_IRQ_MASK);

  // settings
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sel_reg   <= SELECT_RST;
      sens      <= SENS_RST;
      write_ok  <= 1'b0;
      motorless <= 1'b0;
      irq_mask  <= '0;
    end else if (ce) begin
      if (wr_sel) begin
        sel_reg <= hwdata[15:0];
      end
      // out-of-range sensitivity is ignored; writable even while learning
      if (wr_sens && hwdata[15:0] >= SENS_MIN && hwdata[15:0] <= SENS_MAX
          && hwdata[31:16] == 16'h0000) begin
        sens <= hwdata[15:0];
      end
      if (wr_prep) begin
        write_ok  <= hwdata[PREP_WRITE_OK_BIT];
        motorless <= hwdata[PREP_MOTORLESS_BIT];
      end
      if (wr_imask) begin
        irq_mask <= hwdata[IRQ_W-1:0];
      end
    end
  end

  // detection level: learning result wins, software locked out while learning
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      level <= LEVEL_INIT;
    end else if (ce) begin
      if (state == ST_STORE) begin
        if (!slow_err && cand != 16'h0000) begin
          level <= cand;
        end
      end else if (wr_level && state == ST_IDLE) begin
        level <= hwdata[15:0];
      end
    end
  end

  // key timing
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      press_cnt <= 32'h0000_0000;
      key_prev  <= 1'b0;
    end else if (ce) begin
      key_prev <= key_s;
      if (!key_s || state != ST_IDLE) begin
        press_cnt <= 32'h0000_0000;
      end else if (press_cnt < 32'(LONG_PRESS_CNT)) begin
        press_cnt <= press_cnt + 32'h0000_0001;
      end
    end
  end

  // learning sequence
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state     <= ST_IDLE;
      cand      <= 16'h0000;
      slow_err  <= 1'b0;
      learn_out <= '0;
      done_ev   <= 1'b0;
      err_ev    <= 1'b0;
    end else if (ce) begin
      done_ev <= 1'b0;
      err_ev  <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (long_fire) begin
            if (prep_ok) begin
              state     <= ST_LEARN;
              cand      <= 16'h0000;
              slow_err  <= 1'b0;
              learn_out <= '{flash: 1'b1, done: 1'b0, error: 1'b0};
            end else begin
              learn_out <= '{flash: 1'b0, done: 1'b0, error: 1'b1};
              err_ev    <= 1'b1;
            end
          end
        end
        ST_LEARN: begin
          if (vib_speed > cand) begin
            cand <= vib_speed;
          end
          if (slow) begin
            slow_err        <= 1'b1;
            learn_out.error <= 1'b1;
          end
          if (key_rise) begin
            state <= ST_STORE;
          end
        end
        ST_STORE: begin
          state           <= ST_IDLE;
          learn_out.flash <= 1'b0;
          if (slow_err || cand == 16'h0000) begin
            learn_out.error <= 1'b1;
            err_ev          <= 1'b1;
          end else begin
            learn_out.done <= 1'b1;
            done_ev        <= 1'b1;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // warning and alarm outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      vib_out <= '0;
    end else if (ce) begin
      vib_out.warning <= det && (sel_reg[1:0] == SEL_WARN);
      vib_out.alarm   <= det && (sel_reg[1:0] == SEL_ALARM);
    end
  end

  // sticky events, write one to clear; a new event wins over its clear
  logic [IRQ_W-1:0] ev;
  assign ev = {err_ev, done_ev,
               det && (sel_reg[1:0] == SEL_ALARM) && !vib_out.alarm,
               det && (sel_reg[1:0] == SEL_WARN) && !vib_out.warning};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat <= '0;
      irq      <= 1'b0;
    end else if (ce) begin
      irq_stat <= (irq_stat & ~(wr_istat ? hwdata[IRQ_W-1:0] : '0)) | ev;
      irq      <= |(irq_stat & irq_mask);
    end
  end

  // checks
  AST_SEL_NONE: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && sel_reg[1:0] == SEL_NONE) |=> (!vib_out.warning && !vib_out.alarm))
    else $error("detection active with selection none");

  AST_WARN: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && det && sel_reg[1:0] == SEL_WARN) |=> (vib_out.warning && !vib_out.alarm))
    else $error("warning not raised on detection");

  AST_THRESH: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && 32'(vib_speed) * PERCENT <= 32'(level) * 32'(sens))
      |=> (!vib_out.warning && !vib_out.alarm))
    else $error("signal raised at or below threshold");

  AST_SENS_RANGE: assert property (@(posedge hclk) disable iff (!hresetn)
    (sens >= SENS_MIN) && (sens <= SENS_MAX))
    else $error("sensitivity out of range");

  AST_LEVEL_LOCK: assert property (@(posedge hclk) disable iff (!hresetn)
    (state == ST_LEARN) |=> $stable(level))
    else $error("level changed during learning");

  AST_REFUSE: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && state == ST_IDLE && long_fire && !prep_ok)
      |=> (state == ST_IDLE && learn_out.error && $stable(level)))
    else $error("learning started without preconditions");

  AST_START: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && state == ST_IDLE && long_fire && prep_ok)
      |=> (state == ST_LEARN && learn_out.flash && cand == 16'h0000))
    else $error("long press did not start learning");

  AST_SLOW_ERR: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && state == ST_LEARN && slow) |=> (slow_err && learn_out.error))
    else $error("slow speed not flagged");

  AST_STORE: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && state == ST_STORE && !slow_err && cand != 16'h0000)
      |=> (level == $past(cand) && learn_out.done && !learn_out.flash
           && state == ST_IDLE))
    else $error("learned level not stored");

endmodule : vib_detect
`default_nettype wire

// [vib_panel_model.sv]
// Purpose: operator panel model that works the learn key
// Assumes: key is active high; a released key springs back to low
// Notes:   press length is counted in hclk cycles
`timescale 1ns/1ns
`default_nettype none
module vib_panel_model (
  // clock
  input  wire logic hclk,
  // key pin
  output var  logic learn_key
);
  initial learn_key = 1'b0;

  // held long enough this starts learning, a later press ends it
  task automatic press(input int n);
    @(posedge hclk);
    learn_key <= 1'b1;
    repeat (n) @(posedge hclk);
    learn_key <= 1'b0;
  endtask : press
endmodule : vib_panel_model
`default_nettype wire

// [vib_detect_test.sv]
// Purpose: self-checking bench for vibration supervision and level learning
// Assumes: one slave on the bus, zero wait states, long press shortened to 8
// Notes:   every wait is bounded; a timeout counts as a mismatch
`timescale 1ns/1ns
`default_nettype none
module vib_detect_test;
  import vib_pkg::*;
  localparam int LP = 8;
  logic              hclk;
  logic              hresetn;
  logic              ce;
  logic              hsel;
  logic              hwrite;
  logic [1:0]        htrans;
  logic [2:0]        hsize;
  logic [31:0]       haddr;
  logic [31:0]       hwdata;
  logic [31:0]       hrdata;
  logic              hreadyout;
  logic              hresp;
  logic              irq;
  logic              learn_key;
  logic [15:0]       vib_speed;
  logic [15:0]       motor_speed;
  vib_out_s          vib_out;
  learn_out_s        learn_out;
  int                num_errors;
  int                n_tests;

  vib_detect #(.LONG_PRESS_CNT(LP)) i_dut (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .vib_speed(vib_speed), .motor_speed(motor_speed), .learn_key(learn_key),
    .vib_out(vib_out), .learn_out(learn_out), .irq(irq));

  vib_panel_model i_panel (.hclk(hclk), .learn_key(learn_key));

  always #10 hclk = ~hclk;

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wait_rdy();
    int i;
    i = 0;
    do begin
      @(posedge hclk);
      i++;
    end while (hreadyout !== 1'b1 && i < 50);
    if (hreadyout !== 1'b1) begin
      num_errors++;
      test_done();
    end
  endtask : wait_rdy

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= wr;
    hsize  <= 3'b010;
    wait_rdy();
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
    chk("response", 32'h0, {31'h0, hresp});
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask : wr

  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    chk(what, exp, x);
  endtask : rchk

  // waits until any flag of the mask shows on the learn outputs
  task automatic wait_flag(input logic [2:0] m);
    int i;
    i = 0;
    while ((learn_out & m) == 3'b000 && i < 100) begin
      @(posedge hclk);
      i++;
    end
    if ((learn_out & m) == 3'b000) begin
      num_errors++;
      test_done();
    end
  endtask : wait_flag

  task automatic t_reset();
    rchk("select", OFF_SELECT, {16'h0, SELECT_RST});
    rchk("sensitivity", OFF_SENS, 32'h0000_0064);
    rchk("level", OFF_LEVEL, 32'h0000_0032);
    rchk("unmapped", 8'h40, 32'h0);
    chk("outputs", 32'h0, {26'h0, irq, vib_out, learn_out});
  endtask : t_reset

  // out-of-range writes are dropped, both limits are kept
  task automatic t_sens();
    logic [15:0] wv[5] = '{16'h0031, 16'h01f4, 16'h01f5, 16'h0032, 16'h0064};
    logic [15:0] ev[5] = '{16'h0064, 16'h01f4, 16'h01f4, 16'h0032, 16'h0064};
    for (int k = 0; k < 5; k++) begin
      wr(OFF_SENS, {16'h0, wv[k]});
      rchk("sensitivity", OFF_SENS, {16'h0, ev[k]});
    end
  endtask : t_sens

  task automatic t_detect();
    for (int s = 0; s < 4; s++) begin
      wr(OFF_SELECT, s);
      @(posedge hclk) vib_speed <= 16'd51;
      repeat (3) @(posedge hclk);
      chk("over threshold", {30'h0, s == 1, s == 2}, {30'h0, vib_out});
      @(posedge hclk) vib_speed <= 16'd50;
      repeat (3) @(posedge hclk);
      chk("at threshold", 32'h0, {30'h0, vib_out});
    end
    chk("masked irq", 32'h0, {31'h0, irq});
    rchk("events", OFF_IRQ_STAT, 32'h0000_0003);
    wr(OFF_IRQ_MASK, 32'h0000_000f);
    // mask lands at the write's data edge, irq follows one edge later
    repeat (2) @(posedge hclk);
    chk("irq", 32'h1, {31'h0, irq});
    wr(OFF_IRQ_STAT, 32'h0000_0003);
    rchk("events cleared", OFF_IRQ_STAT, 32'h0);
    chk("irq cleared", 32'h0, {31'h0, irq});
    wr(OFF_SENS, 32'h0000_00c8);
    wr(OFF_SELECT, 32'h1);
    @(posedge hclk) vib_speed <= 16'd100;
    repeat (3) @(posedge hclk);
    chk("double sensitivity", 32'h0, {30'h0, vib_out});
    @(posedge hclk) vib_speed <= 16'd101;
    repeat (3) @(posedge hclk);
    chk("double sensitivity", 32'h2, {30'h0, vib_out});
    // clock enable low must hold the raised warning although vibration falls
    @(posedge hclk) ce <= 1'b0;
    vib_speed <= 16'd100;
    repeat (3) @(posedge hclk);
    chk("frozen outputs", 32'h2, {30'h0, vib_out});
    ce <= 1'b1;
    repeat (3) @(posedge hclk);
    chk("enabled outputs", 32'h0, {30'h0, vib_out});
    wr(OFF_SELECT, 32'h0);
    wr(OFF_SENS, 32'h0000_0064);
    wr(OFF_IRQ_STAT, 32'h0000_000f);
  endtask : t_detect

  task automatic t_learn(input logic [1:0] prep, input logic [15:0] spd,
                         input logic [2:0] exp_end);
    logic [31:0] old;
    logic [31:0] x;
    bus(1'b0, OFF_LEVEL, 32'h0, old);
    wr(OFF_PREP, {30'h0, prep});
    @(posedge hclk) motor_speed <= spd;
    @(posedge hclk) vib_speed <= 16'd80;
    i_panel.press(LP + 12);
    if (prep != 2'b01) begin
      wait_flag(3'b001);
      chk("refused start", 32'h1, {29'h0, learn_out});
      rchk("level kept", OFF_LEVEL, old);
      return;
    end
    wait_flag(3'b100);
    chk("flashing", 32'h1, {31'h0, learn_out.flash});
    wr(OFF_LEVEL, 32'h0000_1234);
    rchk("level locked", OFF_LEVEL, old);
    wr(OFF_SENS, 32'h0000_0096);
    rchk("sensitivity open", OFF_SENS, 32'h0000_0096);
    rchk("status", OFF_STATUS, {24'h0, exp_end[0], 3'b010, 2'b01, 1'b0, exp_end[0]});
    rchk("measure", OFF_MEASURE, 32'h0050_0050);
    @(posedge hclk) vib_speed <= 16'd30;
    i_panel.press(6);
    wait_flag(3'b011);
    repeat (2) @(posedge hclk);
    chk("result", {29'h0, exp_end}, {29'h0, learn_out});
    rchk("sensitivity kept", OFF_SENS, 32'h0000_0096);
    if (exp_end == 3'b010) begin
      rchk("learned level", OFF_LEVEL, 32'h0000_0050);
      bus(1'b0, OFF_IRQ_STAT, 32'h0, x);
      chk("done event", 32'h1, {31'h0, x[IRQ_DONE_BIT]});
    end else begin
      rchk("level kept", OFF_LEVEL, old);
    end
    wr(OFF_SENS, 32'h0000_0064);
    wr(OFF_IRQ_STAT, 32'h0000_000f);
  endtask : t_learn

  initial begin
    hclk        = 1'b0;
    hresetn     = 1'b0;
    ce          = 1'b1;
    hsel        = 1'b0;
    haddr       = 32'h0;
    htrans      = 2'b00;
    hwrite      = 1'b0;
    hsize       = 3'b010;
    hwdata      = 32'h0;
    vib_speed   = 16'h0;
    motor_speed = 16'h0;
    num_errors  = 0;
    n_tests     = 0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_sens();
    t_detect();
    t_learn(2'b00, 16'd3000, 3'b001);
    t_learn(2'b11, 16'd3000, 3'b001);
    t_learn(2'b01, 16'd601, 3'b010);
    t_learn(2'b01, 16'd600, 3'b001);
    test_done();
  end
endmodule : vib_detect_test
`default_nettype wire
